// ### afsm_pkg.sv
// Shared constants and types of the framed serial API and socket manager.
// Assumes a single 125 MHz system clock; all settings arrive as plain ports.
package afsm_pkg;
  localparam logic [7:0] FT_CMD_RESP = 8'h88;
  localparam logic [7:0] FT_TX_STATUS = 8'h89;
  localparam logic [7:0] FT_MODEM = 8'h8A;
  localparam logic [7:0] FT_RX_PKT = 8'hB0;
  localparam logic [7:0] CMD_OK = 8'h00;
  localparam logic [7:0] CMD_ERROR = 8'h01;
  localparam logic [7:0] CMD_BAD_CMD = 8'h02;
  localparam logic [7:0] CMD_BAD_PARAM = 8'h03;
  localparam logic [7:0] TX_OK = 8'h00;
  localparam logic [7:0] TX_NET_FAIL = 8'h21;
  localparam logic [7:0] TX_NOT_REG = 8'h22;
  localparam logic [7:0] TX_BAD_FRAME = 8'h2C;
  localparam logic [7:0] TX_INTERNAL = 8'h31;
  localparam logic [7:0] TX_RESOURCE = 8'h32;
  localparam logic [7:0] TX_TOO_LONG = 8'h74;
  localparam logic [7:0] TX_BAD_UDP_PORT = 8'h78;
  localparam logic [7:0] TX_BAD_TCP_PORT = 8'h79;
  localparam logic [7:0] TX_BAD_HOST = 8'h7A;
  localparam logic [7:0] TX_BAD_MODE = 8'h7B;
  localparam logic [7:0] TX_REFUSED = 8'h80;
  localparam logic [7:0] TX_LOST = 8'h81;
  localparam logic [7:0] TX_NO_SERVER = 8'h82;
  localparam logic [7:0] TX_CLOSED = 8'h83;
  localparam logic [7:0] TX_UNKNOWN_SRV = 8'h84;
  localparam logic [7:0] TX_UNKNOWN = 8'h85;
  localparam logic [7:0] MS_POWER_UP = 8'h00;
  localparam logic [7:0] MS_WATCHDOG = 8'h01;
  localparam logic [7:0] MS_REGISTERED = 8'h02;
  localparam logic [7:0] MS_UNREGISTERED = 8'h03;
  localparam logic [7:0] MS_MGMT_UP = 8'h0E;
  localparam logic [7:0] MS_MGMT_DOWN = 8'h0F;
  localparam logic [7:0] PROTO_UDP = 8'h00;
  localparam logic [7:0] PROTO_TCP = 8'h01;
  localparam int OPT_CLOSE_BIT = 1;
  localparam int NUM_SOCK = 7;
  localparam logic [2:0] MAX_SOCK = 3'h7;
  localparam logic [2:0] MAX_SECURE = 3'h4;
  localparam logic [2:0] MGMT_RESERVED = 3'h1;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FRM_MAX = 12;
  localparam logic [3:0] LEN_CMD = 4'h5;
  localparam logic [3:0] LEN_TX = 4'h3;
  localparam logic [3:0] LEN_MODEM = 4'h2;
  localparam logic [3:0] LEN_RX = 4'hC;
  localparam int IDLE_W = 32;

  typedef struct packed {
    logic used;
    logic secure;
    logic incoming;
    logic tcp;
    logic [31:0] addr;
    logic [15:0] rport;
    logic [15:0] lport;
  } afsm_sock_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EMIT = 3'b010,
    ST_DONE = 3'b100
  } afsm_state_t;
endpackage

// ### afsm_byte_if.sv
// Byte stream carrier with valid and ready between the block's own modules.
// Assumes both ends share sys_clk.
`timescale 1ns/10ps
interface afsm_byte_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ### afsm_fifo.sv
// Byte FIFO with a registered output stage, used as the outgoing frame buffer.
// Assumes the drain side may stall for any length of time.
`timescale 1ns/10ps
module afsm_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
  input wire logic sys_clk,
  input wire logic rst,
  afsm_byte_if.snk inPort,
  afsm_byte_if.src outPort
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign inPort.ready = (count != CW'(DEPTH));
  assign push = inPort.valid && inPort.ready;
  assign pop = (count != '0) && (!outPort.valid || outPort.ready);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inPort.data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (pop) begin
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      count <= CW'(count + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outPort.valid <= 1'b0;
      outPort.data <= '0;
    end else if (pop) begin
      outPort.valid <= 1'b1;
      outPort.data <= mem[rdPtr];
    end else if (outPort.ready) begin
      outPort.valid <= 1'b0;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (rst)
    push && !pop |=> count == CW'($past(count) + 1) && count <= CW'(DEPTH))
    else $error("fifo count lost a byte");
endmodule

// ### afsm_idle_timer.sv
// Idle counter of one socket slot; pulses expire when the limit is reached.
// Assumes kick marks any send or receive; a limit of zero never expires.
`timescale 1ns/10ps
module afsm_idle_timer
  import afsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic kick,
  input wire logic [IDLE_W-1:0] limit,
  output logic expire
);
  logic [IDLE_W-1:0] count;
  logic [IDLE_W-1:0] next_count;

  assign next_count = count + 32'h1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run || kick) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      expire <= 1'b0;
    end else begin
      expire <= run && !kick && !expire && (limit != '0) && (next_count == limit);
    end
  end

  chk_idle_kick_clears: assert property (@(posedge sys_clk) disable iff (rst)
    kick |=> !expire && count == '0) else $error("idle counter not restarted by traffic");
endmodule

// ### afsm_top.sv
// Device side of the framed serial API: frame generation and socket table.
// Assumes all inputs come from logic on sys_clk; frames leave as a byte stream.
`timescale 1ns/10ps
// Contract
// - Commands answered with 0x88 response frame.
// - Frame identifier zero suppresses the answer.
// - Status byte codes zero to three.
// - Query appends value; writes omit it. Code appends it only when status is zero.
// - Transmit outcome reported in 0x89 frame.
// - Codes 0x0, 0x21, 0x22 defined.
// - Further transmit failure codes defined.
// - Modem status 0x8A frames on events.
// - Socket data delivered as 0xB0 frame.
// - Seven sockets, at most four secure.
// - Management service reserves one socket.
// - Sockets open implicitly, close on idle.
// - New destination allocates; listen UDP shares.
// - No free socket gives resource error.
// - Listener accepts clients up to limit.
// - Dropped connection retried on next request.
// - Status zero success, nonzero failure.
// - Close on remote, idle or flag.
// - Option bit one closes TCP only.
// - Nonzero source needs exact socket match.
module afsm_top
  import afsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdFrameId,
  input wire logic [15:0] cmdName,
  input wire logic [7:0] cmdStatus,
  input wire logic cmdIsQuery,
  input wire logic [7:0] cmdValue,
  output logic cmdTaken,
  input wire logic txValid,
  input wire logic [7:0] txFrameId,
  input wire logic [31:0] txDestAddr,
  input wire logic [15:0] txDestPort,
  input wire logic [15:0] txSrcPort,
  input wire logic [7:0] txProto,
  input wire logic [7:0] txOptions,
  input wire logic txSecure,
  input wire logic [7:0] txNetCode,
  output logic txTaken,
  input wire logic rxValid,
  input wire logic [2:0] rxSock,
  input wire logic [7:0] rxByte,
  output logic rxTaken,
  input wire logic connValid,
  input wire logic [31:0] connAddr,
  input wire logic [15:0] connPort,
  output logic connTaken,
  output logic connAccepted,
  input wire logic remCloseValid,
  input wire logic [2:0] remCloseSock,
  input wire logic netRegistered,
  input wire logic mgmtConnected,
  input wire logic mgmtEnable,
  input wire logic wdogCause,
  input wire logic [15:0] listenPortSetting,
  input wire logic [7:0] transportProtocolSetting,
  input wire logic [IDLE_W-1:0] clientIdleTimeout,
  input wire logic [IDLE_W-1:0] serverIdleTimeout,
  output logic [NUM_SOCK-1:0] sockOpen,
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady
);
  afsm_byte_if #(.W(BYTE_W)) toFifo ();
  afsm_byte_if #(.W(BYTE_W)) fromFifo ();
  afsm_state_t state;
  afsm_sock_t sock [NUM_SOCK];
  logic [FRM_MAX-1:0][7:0] frm;
  logic [3:0] frmLen;
  logic [3:0] frmIdx;
  logic pendBoot, pendReg, pendUnreg, pendMgOn, pendMgOff;
  logic regPrev, mgPrev;
  logic [NUM_SOCK-1:0] kick, expire;
  logic takeEv, takeCmd, takeTx, takeRx, takeConn;
  logic [7:0] evCode;
  logic [2:0] usedCnt, secCnt, limit, mIdx, fIdx;
  logic mHit, fHit, viaListen, full, txAlloc, txFree, connOk, isTcp;
  logic [7:0] txCode;

  function automatic logic [2:0] countBits(input logic [NUM_SOCK-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_SOCK; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  always_comb begin
    logic [NUM_SOCK-1:0] u;
    logic [NUM_SOCK-1:0] s;
    u = '0;
    s = '0;
    mHit = 1'b0;
    mIdx = 3'h0;
    fHit = 1'b0;
    fIdx = 3'h0;
    isTcp = (txProto == PROTO_TCP);
    for (int i = NUM_SOCK - 1; i >= 0; i--) begin
      u[i] = sock[i].used;
      s[i] = sock[i].used && sock[i].secure;
      if (!sock[i].used) begin
        fHit = 1'b1;
        fIdx = 3'(i);
      end
      if (sock[i].used && sock[i].addr == txDestAddr && sock[i].rport == txDestPort
          && sock[i].lport == txSrcPort && sock[i].tcp == isTcp) begin
        mHit = 1'b1;
        mIdx = 3'(i);
      end
    end
    usedCnt = countBits(u);
    secCnt = countBits(s);
    limit = mgmtEnable ? MAX_SOCK - MGMT_RESERVED : MAX_SOCK;
    full = !fHit || usedCnt >= limit || (txSecure && secCnt >= MAX_SECURE);
    viaListen = !isTcp && txSrcPort == listenPortSetting && txSrcPort != 16'h0
                && transportProtocolSetting == PROTO_UDP;
    txAlloc = 1'b0;
    if (viaListen || mHit) begin
      txCode = txNetCode;
    end else if (txSrcPort != 16'h0) begin
      txCode = TX_CLOSED;
    end else if (full) begin
      txCode = TX_RESOURCE;
    end else begin
      txCode = txNetCode;
      txAlloc = (txNetCode == TX_OK);
    end
    // A failed send on a connection drops it, so the next request retries.
    txFree = mHit && !viaListen && ((isTcp && txOptions[OPT_CLOSE_BIT])
             || txNetCode != TX_OK);
    connOk = transportProtocolSetting == PROTO_TCP && fHit && usedCnt < limit;
  end

  always_comb begin
    takeEv = 1'b0;
    takeCmd = 1'b0;
    takeTx = 1'b0;
    takeRx = 1'b0;
    takeConn = 1'b0;
    evCode = MS_POWER_UP;
    if (state == ST_IDLE) begin
      takeEv = pendBoot | pendReg | pendUnreg | pendMgOn | pendMgOff;
      if (pendBoot) begin
        evCode = wdogCause ? MS_WATCHDOG : MS_POWER_UP;
      end else if (pendReg) begin
        evCode = MS_REGISTERED;
      end else if (pendUnreg) begin
        evCode = MS_UNREGISTERED;
      end else if (pendMgOn) begin
        evCode = MS_MGMT_UP;
      end else begin
        evCode = MS_MGMT_DOWN;
      end
      takeCmd = !takeEv && cmdValid;
      takeTx = !takeEv && !cmdValid && txValid;
      takeRx = !takeEv && !cmdValid && !txValid && rxValid && sock[rxSock].used;
      takeConn = !takeEv && !cmdValid && !txValid && !takeRx && connValid;
    end
  end

  // Event flags: a new edge in the cycle of the clear keeps the flag set.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regPrev <= 1'b0;
      mgPrev <= 1'b0;
      pendBoot <= 1'b1;
      pendReg <= 1'b0;
      pendUnreg <= 1'b0;
      pendMgOn <= 1'b0;
      pendMgOff <= 1'b0;
    end else begin
      regPrev <= netRegistered;
      mgPrev <= mgmtConnected;
      pendBoot <= pendBoot && !takeEv;
      pendReg <= (netRegistered && !regPrev) || (pendReg && !(takeEv && !pendBoot));
      pendUnreg <= (!netRegistered && regPrev)
                   || (pendUnreg && !(takeEv && evCode == MS_UNREGISTERED));
      pendMgOn <= (mgmtConnected && !mgPrev) || (pendMgOn && !(takeEv && evCode == MS_MGMT_UP));
      pendMgOff <= (!mgmtConnected && mgPrev)
                   || (pendMgOff && !(takeEv && evCode == MS_MGMT_DOWN));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      frmLen <= 4'h0;
      frmIdx <= 4'h0;
      frm <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          frmIdx <= 4'h0;
          if (takeEv) begin
            frm[0] <= FT_MODEM;
            frm[1] <= evCode;
            frmLen <= LEN_MODEM;
            state <= ST_EMIT;
          end else if (takeCmd) begin
            frm[0] <= FT_CMD_RESP;
            frm[1] <= cmdFrameId;
            frm[2] <= cmdName[15:8];
            frm[3] <= cmdName[7:0];
            frm[4] <= cmdStatus;
            frm[5] <= cmdValue;
            frmLen <= (cmdIsQuery && cmdStatus == CMD_OK) ? LEN_CMD + 4'h1 : LEN_CMD;
            state <= (cmdFrameId == 8'h00) ? ST_DONE : ST_EMIT;
          end else if (takeTx) begin
            frm[0] <= FT_TX_STATUS;
            frm[1] <= txFrameId;
            frm[2] <= txCode;
            frmLen <= LEN_TX;
            state <= (txFrameId == 8'h00) ? ST_DONE : ST_EMIT;
          end else if (takeRx) begin
            frm[0] <= FT_RX_PKT;
            frm[1] <= sock[rxSock].addr[31:24];
            frm[2] <= sock[rxSock].addr[23:16];
            frm[3] <= sock[rxSock].addr[15:8];
            frm[4] <= sock[rxSock].addr[7:0];
            frm[5] <= sock[rxSock].lport[15:8];
            frm[6] <= sock[rxSock].lport[7:0];
            frm[7] <= sock[rxSock].rport[15:8];
            frm[8] <= sock[rxSock].rport[7:0];
            frm[9] <= sock[rxSock].tcp ? PROTO_TCP : PROTO_UDP;
            frm[10] <= 8'h00;
            frm[11] <= rxByte;
            frmLen <= LEN_RX;
            state <= ST_EMIT;
          end else if (takeConn) begin
            state <= ST_DONE;
          end
        end
        ST_EMIT: begin
          if (toFifo.ready) begin
            frmIdx <= frmIdx + 4'h1;
            if (frmIdx == frmLen - 4'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign toFifo.valid = (state == ST_EMIT);
  assign toFifo.data = frm[frmIdx];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdTaken <= 1'b0;
      txTaken <= 1'b0;
      rxTaken <= 1'b0;
      connTaken <= 1'b0;
      connAccepted <= 1'b0;
    end else begin
      cmdTaken <= takeCmd;
      txTaken <= takeTx;
      rxTaken <= takeRx;
      connTaken <= takeConn;
      connAccepted <= takeConn && connOk;
    end
  end

  // Socket table; closes are applied last so a freed slot is never kept open.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SOCK; i++) begin
        sock[i] <= '0;
      end
    end else begin
      if (takeTx && txAlloc) begin
        sock[fIdx] <= '{used: 1'b1, secure: txSecure, incoming: 1'b0, tcp: isTcp,
                        addr: txDestAddr, rport: txDestPort, lport: 16'h0};
      end
      if (takeConn && connOk) begin
        sock[fIdx] <= '{used: 1'b1, secure: 1'b0, incoming: 1'b1, tcp: 1'b1,
                        addr: connAddr, rport: connPort, lport: listenPortSetting};
      end
      if (takeTx && txFree) begin
        sock[mIdx].used <= 1'b0;
      end
      if (remCloseValid) begin
        sock[remCloseSock].used <= 1'b0;
      end
      for (int i = 0; i < NUM_SOCK; i++) begin
        if (expire[i]) begin
          sock[i].used <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SOCK; i++) begin
      kick[i] = (takeTx && mHit && mIdx == 3'(i)) || (takeRx && rxSock == 3'(i));
    end
  end

  for (genvar g = 0; g < NUM_SOCK; g++) begin : gTimer
    afsm_idle_timer uTimer (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(sock[g].used),
      .kick(kick[g]),
      .limit(sock[g].incoming ? serverIdleTimeout : clientIdleTimeout),
      .expire(expire[g])
    );
    assign sockOpen[g] = sock[g].used;
  end

  afsm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inPort(toFifo),
    .outPort(fromFifo)
  );

  assign outValid = fromFifo.valid;
  assign outData = fromFifo.data;
  assign fromFifo.ready = outReady;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence sFrameHead(logic [7:0] ft);
    state == ST_EMIT && frmIdx == 4'h0 && frm[0] == ft;
  endsequence

  chk_cmd_response: assert property (takeCmd && cmdFrameId != 8'h00 |=>
    sFrameHead(FT_CMD_RESP) ##0 frm[1] == $past(cmdFrameId)) else $error("bad command response");
  chk_zero_id_quiet: assert property ((takeCmd && cmdFrameId == 8'h00)
    || (takeTx && txFrameId == 8'h00) |=> state == ST_DONE ##1 state == ST_IDLE)
    else $error("answer sent for frame id zero");
  chk_query_value: assert property (takeCmd && cmdIsQuery && cmdStatus == CMD_OK
    |=> frmLen == LEN_CMD + 4'h1) else $error("query value missing");
  chk_tx_status: assert property (takeTx && txFrameId != 8'h00 |=>
    sFrameHead(FT_TX_STATUS) ##0 frm[2] == $past(txCode)) else $error("bad transmit status");
  chk_resource_err: assert property (takeTx && !mHit && !viaListen && txSrcPort == 16'h0
    && full |=> frm[2] == TX_RESOURCE && usedCnt == $past(usedCnt))
    else $error("resource error missing");
  chk_sock_limit: assert property (usedCnt <= MAX_SOCK && secCnt <= MAX_SECURE)
    else $error("socket limit exceeded");
  chk_mgmt_reserve: assert property (mgmtEnable && takeConn && connOk
    |-> usedCnt < MAX_SOCK - MGMT_RESERVED) else $error("reserved socket handed out");
  chk_close_flag: assert property (takeTx && mHit && isTcp && txOptions[OPT_CLOSE_BIT]
    |=> !sockOpen[$past(mIdx)]) else $error("close flag ignored");
  chk_rx_frame: assert property (takeRx |=> sFrameHead(FT_RX_PKT) ##0
    frm[11] == $past(rxByte)) else $error("bad receive frame");
  chk_strict_match: assert property (takeTx && txSrcPort != 16'h0 && !mHit && !viaListen
    |=> frm[2] != TX_OK && usedCnt <= $past(usedCnt)) else $error("socket opened for fixed source");
endmodule

// ### afsm_host_model.sv
// Host-side model of the serial API: sinks the outgoing frame byte stream.
// Assumes the device top's output stream on sys_clk; ready stalls at random.
`timescale 1ns/10ps
module afsm_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic outValid,
  input wire logic [7:0] outData,
  output logic outReady,
  output logic gotValid,
  output logic [7:0] gotData
);
  // Ready changes just after each edge and drops about one cycle in four.
  initial begin
    outReady = 1'b0;
    forever begin
      @(posedge sys_clk);
      outReady <= #1 (($urandom % 4) != 0);
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gotValid <= 1'b0;
      gotData <= 8'h00;
    end else begin
      gotValid <= outValid && outReady;
      gotData <= outData;
    end
  end
endmodule

// ### test_api_frame_socket_manager.sv
// Self-checking bench of the frame generator and socket table.
// Assumes afsm_pkg and the host sink model; sockets are indexed 0 to 6.
`timescale 1ns/10ps
module test_api_frame_socket_manager;
  import afsm_pkg::*;
  logic sys_clk, rst, cmdValid, cmdIsQuery, cmdTaken, txValid, txSecure, txTaken, rxValid;
  logic rxTaken, connValid, connTaken, connAccepted, remCloseValid, netRegistered;
  logic mgmtConnected, mgmtEnable, wdogCause, outValid, outReady, gotValid;
  logic [7:0] cmdFrameId, cmdStatus, cmdValue, txFrameId, txProto, txOptions, txNetCode;
  logic [7:0] rxByte, transportProtocolSetting, outData, gotData, d;
  logic [15:0] cmdName, txDestPort, txSrcPort, connPort, listenPortSetting;
  logic [31:0] txDestAddr, connAddr;
  logic [2:0] rxSock, remCloseSock;
  logic [IDLE_W-1:0] clientIdleTimeout, serverIdleTimeout;
  logic [NUM_SOCK-1:0] sockOpen;
  logic [3:0] tk;
  logic [7:0] expQ[$];
  logic [7:0] codes[17];
  int nFail, nTests, j;
  assign tk = {connTaken, rxTaken, txTaken, cmdTaken};

  afsm_top dut (.sys_clk, .rst, .cmdValid, .cmdFrameId, .cmdName, .cmdStatus, .cmdIsQuery,
    .cmdValue, .cmdTaken, .txValid, .txFrameId, .txDestAddr, .txDestPort, .txSrcPort, .txProto,
    .txOptions, .txSecure, .txNetCode, .txTaken, .rxValid, .rxSock, .rxByte, .rxTaken,
    .connValid, .connAddr, .connPort, .connTaken, .connAccepted, .remCloseValid, .remCloseSock,
    .netRegistered, .mgmtConnected, .mgmtEnable, .wdogCause, .listenPortSetting,
    .transportProtocolSetting, .clientIdleTimeout, .serverIdleTimeout, .sockOpen, .outValid,
    .outData, .outReady);
  afsm_host_model host (.sys_clk, .rst, .outValid, .outData, .outReady, .gotValid, .gotData);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    nTests++;
    if (e !== g) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic waitTk(int s);
    int k;
    for (k = 0; k < 300; k++) begin
      step();
      if (tk[s] === 1'b1) break;
    end
    if (k == 300) chk("taken", 8'h01, 8'h00);
  endtask

  task automatic drain();
    for (int k = 0; k < 400 && expQ.size() > 0; k++) step();
    repeat (4) step();
    chk("pending", 8'h00, 8'(expQ.size()));
  endtask

  task automatic cnt(int e);
    chk("sockOpen", 8'(e), 8'($countones(sockOpen)));
  endtask

  task automatic sendCmd(logic [7:0] id, logic [7:0] st, logic q);
    step();
    cmdFrameId = id;
    cmdName = 16'h4E52;
    cmdStatus = st;
    cmdIsQuery = q;
    cmdValue = 8'($urandom);
    if (id != 8'h00) expQ = {expQ, FT_CMD_RESP, id, 8'h4E, 8'h52, st};
    if (id != 8'h00 && q && st == CMD_OK) expQ.push_back(cmdValue);
    cmdValid = 1'b1;
    waitTk(0);
    cmdValid = 1'b0;
    drain();
  endtask

  task automatic sendTx(logic [7:0] id, int n, logic [15:0] sp, logic [7:0] pr,
                        logic [7:0] op, logic sec, logic [7:0] nc, logic [7:0] e);
    step();
    {txFrameId, txSrcPort, txProto, txOptions, txSecure, txNetCode} = {id, sp, pr, op, sec, nc};
    txDestAddr = 32'h0A000000 + 32'(n);
    txDestPort = 16'h1000 + 16'(n);
    if (id != 8'h00) expQ = {expQ, FT_TX_STATUS, id, e};
    txValid = 1'b1;
    waitTk(1);
    txValid = 1'b0;
    drain();
  endtask

  task automatic closeAll();
    for (int k = 0; k < NUM_SOCK; k++) begin
      step();
      remCloseSock = 3'(k);
      remCloseValid = 1'b1;
    end
    step();
    remCloseValid = 1'b0;
    step();
  endtask

  task automatic sendConn(int n, logic e);
    step();
    connAddr = 32'hC0000000 + 32'(n);
    connPort = 16'h2000;
    connValid = 1'b1;
    waitTk(3);
    connValid = 1'b0;
    chk("connAccepted", 8'(e), 8'(connAccepted));
  endtask

  // Each byte the host took is matched against the oldest expected byte.
  always @(posedge sys_clk) begin
    if (gotValid === 1'b1 && expQ.size() == 0) chk("outData", 8'hXX, gotData);
    else if (gotValid === 1'b1) chk("outData", expQ.pop_front(), gotData);
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    nFail++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hafac81e3));
    {cmdValid, txValid, rxValid, connValid, remCloseValid, netRegistered, mgmtConnected} = '0;
    {mgmtEnable, wdogCause, cmdIsQuery, txSecure, cmdFrameId, cmdStatus, cmdValue} = '0;
    {txFrameId, txProto, txOptions, txNetCode, rxByte, cmdName, txDestPort, txSrcPort} = '0;
    {connPort, txDestAddr, connAddr, rxSock, remCloseSock, clientIdleTimeout} = '0;
    serverIdleTimeout = '0;
    listenPortSetting = 16'h1F90;
    transportProtocolSetting = PROTO_UDP;
    codes = '{TX_OK, TX_NET_FAIL, TX_NOT_REG, TX_BAD_FRAME, TX_INTERNAL, TX_RESOURCE,
      TX_TOO_LONG, TX_BAD_UDP_PORT, TX_BAD_TCP_PORT, TX_BAD_HOST, TX_BAD_MODE, TX_REFUSED,
      TX_LOST, TX_NO_SERVER, TX_CLOSED, TX_UNKNOWN_SRV, TX_UNKNOWN};
    rst = 1'b1;
    expQ = {FT_MODEM, MS_POWER_UP};
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    drain();
    netRegistered = 1'b1;
    expQ = {FT_MODEM, MS_REGISTERED};
    drain();
    netRegistered = 1'b0;
    mgmtConnected = 1'b1;
    expQ = {FT_MODEM, MS_UNREGISTERED, FT_MODEM, MS_MGMT_UP};
    drain();
    mgmtConnected = 1'b0;
    expQ = {FT_MODEM, MS_MGMT_DOWN};
    drain();
    sendCmd(8'h05, CMD_OK, 1'b1);
    for (int s = 0; s < 4; s++) sendCmd(8'(s + 1), 8'(s), 1'b0);
    sendCmd(8'hA1, CMD_BAD_PARAM, 1'b1);
    sendCmd(8'h00, CMD_OK, 1'b1);
    for (int c = 0; c < 17; c++) begin
      sendTx(8'(c + 1), c, 16'h0, PROTO_TCP, 8'h00, 1'b0, codes[c],
             codes[c]);
    end
    cnt(1);
    sendTx(8'h00, 40, 16'h0, PROTO_UDP, 8'h00, 1'b0, TX_OK, TX_OK);
    closeAll();
    cnt(0);
    mgmtEnable = 1'b1;
    for (int n = 0; n < 7; n++) begin
      sendTx(8'h30, n, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK,
             n < 6 ? TX_OK : TX_RESOURCE);
    end
    mgmtEnable = 1'b0;
    sendTx(8'h31, 6, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_OK);
    sendTx(8'h32, 7, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_RESOURCE);
    cnt(7);
    sendTx(8'h33, 9, 16'h1F90, PROTO_UDP, 8'h00, 1'b0, TX_OK, TX_OK);
    sendTx(8'h34, 9, 16'h4321, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_CLOSED);
    sendTx(8'h35, 3, 16'h0, PROTO_TCP, 8'h02, 1'b0, TX_OK, TX_OK);
    cnt(6);
    sendTx(8'h36, 8, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_OK);
    sendTx(8'h37, 8, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_OK);
    cnt(7);
    closeAll();
    for (int n = 0; n < 5; n++) begin
      sendTx(8'h40, n, 16'h0, PROTO_TCP, 8'h00, 1'b1, TX_OK,
             n < 4 ? TX_OK : TX_RESOURCE);
    end
    closeAll();
    sendTx(8'h41, 20, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_OK);
    j = 0;
    for (int k = 0; k < NUM_SOCK; k++) if (sockOpen[k] === 1'b1) j = k;
    clientIdleTimeout = 32'd60;
    step();
    d = 8'($urandom);
    rxSock = 3'(j);
    rxByte = d;
    expQ = {FT_RX_PKT, 8'h0A, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00, 8'h10, 8'h14, PROTO_TCP,
            8'h00, d};
    rxValid = 1'b1;
    waitTk(2);
    rxValid = 1'b0;
    repeat (30) step();
    cnt(1);
    repeat (50) step();
    cnt(0);
    drain();
    clientIdleTimeout = '0;
    sendTx(8'h42, 20, 16'h0, PROTO_TCP, 8'h00, 1'b0, TX_OK, TX_OK);
    transportProtocolSetting = PROTO_TCP;
    mgmtEnable = 1'b1;
    for (int n = 0; n < 6; n++) sendConn(n, n < 5);
    mgmtEnable = 1'b0;
    sendConn(6, 1'b1);
    sendConn(7, 1'b0);
    cnt(7);
    // A second reset in mid-run reports the watchdog as the boot cause.
    wdogCause = 1'b1;
    rst = 1'b1;
    expQ = {FT_MODEM, MS_WATCHDOG};
    repeat (3) step();
    cnt(0);
    rst = 1'b0;
    drain();
    end_sim();
  end
endmodule
